// file: drvsp_pkg.sv
// Shared constants and types for the drive stop and protection parameter bank
`default_nettype none
package drvsp_pkg;
   // Register indices; the byte address on the bus is four times the index
   localparam logic [15:0] IDX_DISP = 16'h10d8;
   localparam logic [15:0] IDX_STOP = 16'h10da;
   localparam logic [15:0] IDX_FAN = 16'h10db;
   localparam logic [15:0] IDX_PEN = 16'h10f5;
   localparam logic [15:0] IDX_PLVL = 16'h10f6;
   localparam logic [15:0] IDX_OCS = 16'h10f7;
   localparam logic [15:0] IDX_CAR = 16'h10f8;
   localparam logic [15:0] IDX_RDY = 16'h10f9;
   localparam logic [15:0] IDX_REN = 16'h1176;
   localparam logic [15:0] IDX_RLVL = 16'h1177;
   localparam logic [15:0] IDX_STAT = 16'h1200;
   // Legal codes and ranges
   localparam logic [15:0] DISP_MIN = 16'h0001;
   localparam logic [15:0] DISP_MAX = 16'h0007;
   localparam logic [15:0] BIN_MAX = 16'h0001;
   localparam logic [15:0] FAN_MAX = 16'h0002;
   localparam logic STOP_RAMP = 1'h0;
   localparam logic STOP_COAST = 1'h1;
   localparam logic [1:0] FAN_ALWAYS = 2'h0;
   localparam logic [1:0] FAN_RUN = 2'h1;
   localparam logic [1:0] FAN_TEMP = 2'h2;
   localparam logic [15:0] LV_LO_MIN = 16'h014a;
   localparam logic [15:0] LV_LO_MAX = 16'h018b;
   localparam logic [15:0] LV_HI_MIN = 16'h0294;
   localparam logic [15:0] LV_HI_MAX = 16'h0316;
   // Timing: fan run-on time in minutes, clock rate in hertz
   localparam longint unsigned FAN_DELAY_MIN = 64'h5;
   localparam longint unsigned SEC_PER_MIN = 64'h3c;
   localparam longint unsigned CLK_HZ = 64'h1312d00;
   localparam longint unsigned FAN_DELAY_CYC = FAN_DELAY_MIN * SEC_PER_MIN * CLK_HZ;
   localparam int unsigned FAN_CW = 36;
   // Bus handshake states
   typedef enum logic {BS_IDLE, BS_ANS} drvsp_bus_e;
   // Stored settings
   typedef struct packed {
      logic [2:0] disp;
      logic stop;
      logic [1:0] fan;
      logic pen;
      logic [9:0] plvl;
      logic ocs;
      logic car;
      logic rdy;
      logic ren;
      logic [9:0] rlvl;
   } drvsp_cfg_s;
   // Settings after reset; levels sit inside the lower class range
   localparam drvsp_cfg_s CFG_RST = '{disp: 3'h1, stop: STOP_RAMP, fan: FAN_ALWAYS, pen: 1'h0,
      plvl: 10'h17c, ocs: 1'h0, car: 1'h0, rdy: 1'h0, ren: 1'h0, rlvl: 10'h17c};
   // Controls handed to the drive logic
   typedef struct packed {
      logic fan_on;
      logic decel_hold;
      logic coast_stop;
      logic bus_reg_active;
      logic carrier_reduce;
      logic trip_suppress;
      logic ready_en;
      logic [2:0] display_sel;
   } drvsp_ctl_s;
endpackage
`default_nettype wire

// file: drvsp_bank.sv
// Stop and protection parameter bank with Avalon-MM register access
//
// Summary of operation
// RL1 - Display select also accepts codes 6 and 7
// RL2 - Stop method: 0 ramp down, 1 coast
// RL3 - Fan: 0 always, 1 run-only, 2 temperature
// RL4 - Run-only fan stays on five minutes after stop
// RL5 - One-bit enable for over-voltage deceleration hold
// RL6 - Hold deceleration while bus voltage above level
// RL7 - Levels: 330-395 low class, 660-790 high
// RL8 - Bus regulation enable plus level, same ranges
// RL9 - Carrier auto-reduce on heat when enabled
// RL10 - Out-of-range writes refused, old value kept
`default_nettype none
module drvsp_bank #(
   parameter longint unsigned FAN_OFF_CYC = drvsp_pkg::FAN_DELAY_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic run_pin,
   input wire logic amb_hot_pin,
   input wire logic sink_hot_pin,
   input wire logic hv_class_pin,
   input wire logic [9:0] dc_bus_volts,
   output drvsp_pkg::drvsp_ctl_s ctl_out
);
   import drvsp_pkg::*;

   // Whole module state in one word
   typedef struct packed {
      drvsp_bus_e bus;
      logic wait_r;
      logic [31:0] rdata;
      drvsp_cfg_s cfg;
      drvsp_ctl_s ctl;
      logic [1:0] run_s;
      logic [1:0] amb_s;
      logic [1:0] hot_s;
      logic [1:0] cls_s;
      logic [FAN_CW-1:0] fan_cnt;
   } drvsp_st_s;

   // Waitrequest idles high so no access slips through unseen
   localparam drvsp_st_s ST_RST = '{bus: BS_IDLE, wait_r: 1'h1, rdata: 32'h0, cfg: CFG_RST,
      ctl: '0, run_s: 2'h0, amb_s: 2'h0, hot_s: 2'h0, cls_s: 2'h0, fan_cnt: '0};
   localparam logic [FAN_CW-1:0] FAN_LOAD = FAN_CW'(FAN_OFF_CYC);

   drvsp_st_s q_reg; // Registered state
   drvsp_st_s q_next; // Next state
   logic hv; // High voltage class, synchronised
   logic be_ok; // Both low byte lanes enabled
   logic [15:0] wdat; // Low half of write data
   logic wr_legal; // Write value within its range

   // Level range depends on the voltage class
   function automatic logic lvl_ok(input logic [15:0] v, input logic hc);
      if (hc) begin
         lvl_ok = (v >= LV_HI_MIN) && (v <= LV_HI_MAX); // [RL7]
      end else begin
         lvl_ok = (v >= LV_LO_MIN) && (v <= LV_LO_MAX); // [RL7]
      end
   endfunction

   // Legal value check per register; unknown or read-only index refuses
   function automatic logic wr_ok(input logic [15:0] a, input logic [15:0] v, input logic hc);
      case (a)
         IDX_DISP: wr_ok = (v >= DISP_MIN) && (v <= DISP_MAX); // [RL1]
         IDX_STOP, IDX_PEN, IDX_OCS, IDX_CAR, IDX_RDY, IDX_REN: begin
            wr_ok = v <= BIN_MAX; // [RL2] [RL5] [RL8] [RL9]
         end
         IDX_FAN: wr_ok = v <= FAN_MAX; // [RL3]
         IDX_PLVL, IDX_RLVL: wr_ok = lvl_ok(v, hc); // [RL7] [RL8]
         default: wr_ok = 1'h0;
      endcase
   endfunction

   assign hv = q_reg.cls_s[1];
   assign be_ok = &avs_byteenable[1:0];
   assign wdat = avs_writedata[15:0];
   assign wr_legal = be_ok && wr_ok(avs_address, wdat, hv); // [RL10]

   // Next state: synchronisers, bus slave, settings, control outputs
   always_comb begin
      logic [15:0] rv;
      rv = 16'h0000;
      q_next = q_reg;
      // Pins pass two flops; only the second stage is used
      q_next.run_s = {q_reg.run_s[0], run_pin};
      q_next.amb_s = {q_reg.amb_s[0], amb_hot_pin};
      q_next.hot_s = {q_reg.hot_s[0], sink_hot_pin};
      q_next.cls_s = {q_reg.cls_s[0], hv_class_pin};
      // Read multiplexer; unmapped indices read zero
      case (avs_address)
         IDX_DISP: rv = 16'(q_reg.cfg.disp);
         IDX_STOP: rv = 16'(q_reg.cfg.stop);
         IDX_FAN: rv = 16'(q_reg.cfg.fan);
         IDX_PEN: rv = 16'(q_reg.cfg.pen);
         IDX_PLVL: rv = 16'(q_reg.cfg.plvl);
         IDX_OCS: rv = 16'(q_reg.cfg.ocs);
         IDX_CAR: rv = 16'(q_reg.cfg.car);
         IDX_RDY: rv = 16'(q_reg.cfg.rdy);
         IDX_REN: rv = 16'(q_reg.cfg.ren);
         IDX_RLVL: rv = 16'(q_reg.cfg.rlvl);
         IDX_STAT: rv = 16'({hv, q_reg.run_s[1], q_reg.ctl.fan_on, q_reg.ctl.decel_hold,
            q_reg.ctl.bus_reg_active, q_reg.ctl.carrier_reduce, q_reg.ctl.coast_stop});
         default: rv = 16'h0000;
      endcase
      // Bus slave: one wait cycle, then the answer edge
      case (q_reg.bus)
         BS_IDLE: begin
            if (avs_read || avs_write) begin
               q_next.bus = BS_ANS;
               q_next.wait_r = 1'h0;
               q_next.rdata = avs_read ? {16'h0000, rv} : 32'h0;
            end
         end
         BS_ANS: begin
            // Write lands on the edge the master sees waitrequest low
            q_next.bus = BS_IDLE;
            q_next.wait_r = 1'h1;
            if (avs_write && wr_legal) begin // [RL10]
               case (avs_address)
                  IDX_DISP: q_next.cfg.disp = wdat[2:0]; // [RL1]
                  IDX_STOP: q_next.cfg.stop = wdat[0]; // [RL2]
                  IDX_FAN: q_next.cfg.fan = wdat[1:0]; // [RL3]
                  IDX_PEN: q_next.cfg.pen = wdat[0]; // [RL5]
                  IDX_PLVL: q_next.cfg.plvl = wdat[9:0]; // [RL7]
                  IDX_OCS: q_next.cfg.ocs = wdat[0];
                  IDX_CAR: q_next.cfg.car = wdat[0]; // [RL9]
                  IDX_RDY: q_next.cfg.rdy = wdat[0];
                  IDX_REN: q_next.cfg.ren = wdat[0]; // [RL8]
                  IDX_RLVL: q_next.cfg.rlvl = wdat[9:0]; // [RL8]
                  default: q_next.cfg = q_reg.cfg;
               endcase
            end
         end
         default: begin
            q_next.bus = BS_IDLE;
            q_next.wait_r = 1'h1;
         end
      endcase
      // Run-on timer reloads while running, counts down once stopped
      if (q_reg.run_s[1]) begin
         q_next.fan_cnt = FAN_LOAD; // [RL4]
      end else if (q_reg.fan_cnt != '0) begin
         q_next.fan_cnt = q_reg.fan_cnt - 1'b1; // [RL4]
      end
      // Fan policy; an illegal code cannot be stored, default keeps fan on
      case (q_reg.cfg.fan)
         FAN_ALWAYS: q_next.ctl.fan_on = 1'h1; // [RL3]
         FAN_RUN: q_next.ctl.fan_on = q_reg.run_s[1] || (q_reg.fan_cnt != '0); // [RL4]
         FAN_TEMP: q_next.ctl.fan_on = q_reg.hot_s[1]; // [RL3]
         default: q_next.ctl.fan_on = 1'h1;
      endcase
      // Hold ramp above level, release below; equal keeps state
      if (!q_reg.cfg.pen) begin
         q_next.ctl.decel_hold = 1'h0; // [RL5]
      end else if (dc_bus_volts > q_reg.cfg.plvl) begin
         q_next.ctl.decel_hold = 1'h1; // [RL6]
      end else if (dc_bus_volts < q_reg.cfg.plvl) begin
         q_next.ctl.decel_hold = 1'h0; // [RL6]
      end
      q_next.ctl.coast_stop = q_reg.cfg.stop == STOP_COAST; // [RL2]
      q_next.ctl.bus_reg_active = q_reg.cfg.ren && (dc_bus_volts > q_reg.cfg.rlvl); // [RL8]
      q_next.ctl.carrier_reduce = q_reg.cfg.car && q_reg.amb_s[1]; // [RL9]
      q_next.ctl.trip_suppress = q_reg.cfg.ocs;
      q_next.ctl.ready_en = q_reg.cfg.rdy;
      q_next.ctl.display_sel = q_reg.cfg.disp; // [RL1]
   end

   // State register; reset loads constants only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q_reg <= ST_RST;
      end else begin
         q_reg <= q_next;
      end
   end

   // Outputs straight from flops
   assign avs_readdata = q_reg.rdata;
   assign avs_waitrequest = q_reg.wait_r;
   assign ctl_out = q_reg.ctl;

   // Checks on the bank's own behaviour
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   // A write taken at the answer edge
   sequence s_wr_take;
      avs_write && !avs_waitrequest;
   endsequence

   // A read request followed by its answer
   sequence s_req_ans;
      (avs_read && avs_waitrequest && q_reg.bus == BS_IDLE) ##1 !avs_waitrequest;
   endsequence

   a_disp_code_six: // [RL1]
   assert property ((s_wr_take ##0 (wr_legal && avs_address == IDX_DISP && wdat == 16'h0006))
      |=> q_reg.cfg.disp == 3'h6 ##1 ctl_out.display_sel == 3'h6)
      else $error("display code 6 not applied");

   a_coast_follow: // [RL2]
   assert property (q_reg.cfg.stop == STOP_COAST |=> ctl_out.coast_stop)
      else $error("coast stop not driven");

   a_fan_always_on: // [RL3]
   assert property (q_reg.cfg.fan == FAN_ALWAYS |=> ctl_out.fan_on)
      else $error("fan off in always-on mode");

   a_fan_run_on: // [RL4]
   assert property ((q_reg.cfg.fan == FAN_RUN && $fell(q_reg.run_s[1]))
      |-> q_reg.fan_cnt == FAN_LOAD ##1 (ctl_out.fan_on && q_reg.fan_cnt == FAN_LOAD - 1'b1))
      else $error("fan run-on timer not started");

   a_hold_release: // [RL5]
   assert property (!q_reg.cfg.pen |=> !ctl_out.decel_hold)
      else $error("hold active while disabled");

   a_hold_above: // [RL6]
   assert property ((q_reg.cfg.pen && dc_bus_volts > q_reg.cfg.plvl) |=> ctl_out.decel_hold)
      else $error("deceleration not held above level");

   a_level_range: // [RL7]
   assert property ((s_wr_take ##0 (avs_address == IDX_PLVL && !lvl_ok(wdat, hv)))
      |=> $stable(q_reg.cfg.plvl))
      else $error("out of range pause level stored");

   a_reg_active: // [RL8]
   assert property ((q_reg.cfg.ren && dc_bus_volts > q_reg.cfg.rlvl) |=> ctl_out.bus_reg_active)
      else $error("bus regulation not started");

   a_carrier_cut: // [RL9]
   assert property (!q_reg.cfg.car |=> !ctl_out.carrier_reduce)
      else $error("carrier reduced while disabled");

   a_bad_refused: // [RL10]
   assert property ((s_wr_take ##0 !wr_legal) |=> $stable(q_reg.cfg))
      else $error("illegal write changed settings");

   a_read_answer:
   assert property (s_req_ans |-> avs_readdata[31:16] == 16'h0000)
      else $error("read upper half not zero");

   // Handshake shape: one wait cycle, then low for exactly one cycle
   a_req_answered:
   assert property ((q_reg.bus == BS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest)
      else $error("request not answered after one wait");

   a_wait_one_cycle:
   assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");

   a_disp_follow: // [RL1]
   assert property (1'b1 |=> ctl_out.display_sel == $past(q_reg.cfg.disp))
      else $error("display select not following setting");

   a_ramp_follow: // [RL2]
   assert property (q_reg.cfg.stop == STOP_RAMP |=> !ctl_out.coast_stop)
      else $error("coast stop driven in ramp mode");

   a_stop_stored: // [RL2]
   assert property ((s_wr_take ##0 (wr_legal && avs_address == IDX_STOP)) |=> q_reg.cfg.stop == $past(wdat[0]))
      else $error("legal stop method write not stored");

   a_fan_temp_follow: // [RL3]
   assert property (q_reg.cfg.fan == FAN_TEMP |=> ctl_out.fan_on == $past(q_reg.hot_s[1]))
      else $error("fan not following heatsink temperature");

   a_fan_run_hold: // [RL4]
   assert property ((q_reg.cfg.fan == FAN_RUN && q_reg.fan_cnt != '0) |=> ctl_out.fan_on)
      else $error("fan off during run-on time");

   a_fan_run_off: // [RL4]
   assert property ((q_reg.cfg.fan == FAN_RUN && !q_reg.run_s[1] && q_reg.fan_cnt == '0) |=> !ctl_out.fan_on)
      else $error("fan on after run-on time");

   a_hold_below: // [RL6]
   assert property ((q_reg.cfg.pen && dc_bus_volts < q_reg.cfg.plvl) |=> !ctl_out.decel_hold)
      else $error("deceleration held below level");

   a_hold_equal_keep: // [RL6]
   assert property ((q_reg.cfg.pen && dc_bus_volts == q_reg.cfg.plvl) |=> $stable(ctl_out.decel_hold))
      else $error("hold changed at equal voltage");

   a_reg_at_level: // [RL8]
   assert property ((q_reg.cfg.ren && dc_bus_volts <= q_reg.cfg.rlvl) |=> !ctl_out.bus_reg_active)
      else $error("bus regulation active at or below level");

   a_rlvl_range: // [RL8]
   assert property ((s_wr_take ##0 (avs_address == IDX_RLVL && !lvl_ok(wdat, hv))) |=> $stable(q_reg.cfg.rlvl))
      else $error("out of range regulation level stored");

   a_carrier_heat: // [RL9]
   assert property ((q_reg.cfg.car && q_reg.amb_s[1]) |=> ctl_out.carrier_reduce)
      else $error("carrier not reduced when hot");

   // Partial lane writes could tear a value, so they are refused whole
   a_lane_refused: // [RL10]
   assert property ((s_wr_take ##0 !be_ok) |=> $stable(q_reg.cfg))
      else $error("partial lane write changed settings");
endmodule
`default_nettype wire

// file: drvsp_master.sv
// Avalon-MM master model standing in for the network master
`default_nettype none
module drvsp_master (
   input wire logic clk_sys,
   output logic [15:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   timeunit 1ns;
   timeprecision 100ps;
   // Bus idles with no request at time zero
   initial begin
      avs_address = 16'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end
   // One access, held until waitrequest is seen low at a rising edge
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] be,
         output logic [31:0] q);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= ~wr;
      // Waits as long as the slave asks; only the bench watchdog ends a hang
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Released address and data lines do not keep the last value, so stale use shows up
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the stop and protection parameter bank
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import drvsp_pkg::*;
   localparam longint unsigned OFF_CYC = 64'h14; // Fan run-on cut to 20 cycles
   localparam logic [15:0] IDXS [10] = '{IDX_STOP, IDX_FAN, IDX_PEN, IDX_OCS, IDX_CAR, IDX_RDY, IDX_REN,
      IDX_DISP, IDX_PLVL, IDX_RLVL};
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] avs_address;
   logic avs_read, avs_write;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic avs_waitrequest;
   logic run_pin = 1'b0, amb_hot_pin = 1'b0, sink_hot_pin = 1'b0, hv_class_pin = 1'b0;
   logic [9:0] dc_bus_volts = 10'h0;
   drvsp_ctl_s ctl_out;
   logic [15:0] shadow [logic [15:0]]; // Expected contents of each register
   int mismatches = 0;
   int n_tests = 0;
   // 20 MHz system clock
   always #25 clk_sys = ~clk_sys;
   drvsp_bank #(.FAN_OFF_CYC(OFF_CYC)) u_drvsp_bank (.clk_sys(clk_sys), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .run_pin(run_pin), .amb_hot_pin(amb_hot_pin), .sink_hot_pin(sink_hot_pin), .hv_class_pin(hv_class_pin),
      .dc_bus_volts(dc_bus_volts), .ctl_out(ctl_out));
   drvsp_master u_drvsp_master (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   // Whether a value is one the register accepts in the present class
   function automatic logic legal(input logic [15:0] i, input logic [15:0] v);
      case (i)
         IDX_DISP: return v >= DISP_MIN && v <= DISP_MAX;
         IDX_FAN: return v <= FAN_MAX;
         IDX_PLVL, IDX_RLVL: return hv_class_pin ? (v >= LV_HI_MIN && v <= LV_HI_MAX) :
            (v >= LV_LO_MIN && v <= LV_LO_MAX);
         default: return v <= BIN_MAX;
      endcase
   endfunction
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: control %b, expected %b", $time, got, exp);
      end
   endtask
   // Wait n edges, then look at settled outputs on the falling edge
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   // Write, update the expectation only when legal, read back
   task automatic put(input logic [15:0] i, input logic [15:0] v, input logic [3:0] be);
      logic [31:0] q;
      u_drvsp_master.xfer(1'b1, i, {16'h0, v}, be, q);
      if (be[1:0] == 2'b11 && legal(i, v)) begin
         shadow[i] = v;
      end
      u_drvsp_master.xfer(1'b0, i, 32'h0, 4'hf, q);
      chk_val(q, {16'h0, shadow[i]});
   endtask
   // Pins as {run, ambient hot, sink hot, high class}, plus bus voltage
   task automatic drive(input logic [3:0] p, input logic [9:0] v);
      @(posedge clk_sys);
      {run_pin, amb_hot_pin, sink_hot_pin, hv_class_pin} <= p;
      dc_bus_volts <= v;
   endtask
   task automatic test_done;
      $display("%0d comparisons, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog: the tests need about a thousand cycles
   initial begin
      repeat (30000) @(posedge clk_sys);
      mismatches++;
      test_done();
   end
   // Main sequence
   initial begin
      logic [31:0] q;
      logic [15:0] lv [8];
      logic [9:0] vt [3];
      lv = '{16'd329, 16'd330, 16'd395, 16'd396, 16'd659, 16'd660, 16'd790, 16'd791};
      vt = '{10'd791, 10'd790, 10'd789};
      foreach (IDXS[k]) shadow[IDXS[k]] = 16'h0;
      shadow[IDX_DISP] = 16'h1;
      shadow[IDX_PLVL] = 16'h17c;
      shadow[IDX_RLVL] = 16'h17c;
      void'($urandom(32'hf038));
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (IDXS[k]) begin
         u_drvsp_master.xfer(1'b0, IDXS[k], 32'h0, 4'hf, q);
         chk_val(q, {16'h0, shadow[IDXS[k]]});
      end
      u_drvsp_master.xfer(1'b0, 16'h1234, 32'h0, 4'hf, q);
      chk_val(q, 32'h0);
      chk_bit(ctl_out.fan_on, 1'b1);
      u_drvsp_master.xfer(1'b0, IDX_STAT, 32'h0, 4'hf, q);
      chk_val(q, 32'h10);
      $display("test reset values done");
      // Every code of the coded registers, and the ones just beyond
      for (int v = 0; v < 9; v++) begin
         for (int k = 0; k < 8; k++) put(IDXS[k], v[15:0], 4'h3);
      end
      put(IDX_STOP, 16'h0, 4'h1);
      wt(2);
      chk_bit(ctl_out.display_sel == 3'h7, 1'b1);
      chk_bit(ctl_out.coast_stop, 1'b1);
      chk_bit(ctl_out.trip_suppress & ctl_out.ready_en, 1'b1);
      $display("test option codes done");
      // Level edges in both voltage classes
      for (int k = 0; k < 8; k++) begin
         if (k == 4) begin
            drive(4'h1, 10'h0);
            wt(4);
         end
         put(IDX_PLVL, lv[k], 4'h3);
         put(IDX_RLVL, lv[k], 4'h3);
      end
      // Deceleration hold and bus regulation around a level of 790
      for (int k = 0; k < 3; k++) begin
         drive(4'h1, vt[k]);
         wt(4);
         chk_bit(ctl_out.decel_hold, k < 2);
         chk_bit(ctl_out.bus_reg_active, k == 0);
      end
      drive(4'h1, 10'd800);
      put(IDX_PEN, 16'h0, 4'h3);
      wt(4);
      chk_bit(ctl_out.decel_hold, 1'b0);
      $display("test levels done");
      // Fan by temperature, then run-only with its run-on time
      drive(4'h3, 10'h0);
      wt(4);
      chk_bit(ctl_out.fan_on, 1'b1);
      drive(4'h1, 10'h0);
      wt(4);
      chk_bit(ctl_out.fan_on, 1'b0);
      put(IDX_FAN, 16'h1, 4'h3);
      drive(4'h9, 10'h0);
      wt(4);
      chk_bit(ctl_out.fan_on, 1'b1);
      drive(4'h1, 10'h0);
      wt(12);
      chk_bit(ctl_out.fan_on, 1'b1);
      wt(30);
      chk_bit(ctl_out.fan_on, 1'b0);
      $display("test fan done");
      // Carrier reduction follows ambient heat only while enabled
      drive(4'h5, 10'h0);
      wt(4);
      chk_bit(ctl_out.carrier_reduce, 1'b1);
      put(IDX_CAR, 16'h0, 4'h3);
      wt(3);
      chk_bit(ctl_out.carrier_reduce, 1'b0);
      $display("test carrier done");
      // Random writes, codes and levels mixed, legal and not
      repeat (60) begin
         put(IDXS[$urandom_range(0, 9)], $urandom_range(0, 1) ? 16'($urandom_range(0, 9)) :
            16'($urandom_range(640, 800)), 4'h3);
      end
      $display("test random writes done");
      test_done();
   end
endmodule
`default_nettype wire
